// file: hw/nvm_ctrl_pkg.sv
/*
 * constants for the indirect memory access and device action register block.
 * assumes a 100 MHz ref_clk and 16-bit registers at byte-pair offsets.
 */
package nvm_ctrl_pkg;
	// =========================================================
	// register offsets (byte address of the register)
	localparam logic [7:0] OFS_WR_TARGET   = 8'h02;
	localparam logic [7:0] OFS_WR_UPPER    = 8'h04;
	localparam logic [7:0] OFS_WR_LOWER    = 8'h06;
	localparam logic [7:0] OFS_WR_STATE    = 8'h08;
	localparam logic [7:0] OFS_RD_SOURCE   = 8'h0a;
	localparam logic [7:0] OFS_RD_STATE    = 8'h0c;
	localparam logic [7:0] OFS_RD_UPPER    = 8'h0e;
	localparam logic [7:0] OFS_RD_LOWER    = 8'h10;
	localparam logic [7:0] OFS_CTRL        = 8'h1e;
	// =========================================================
	// field positions
	localparam int START_BIT = 15;
	localparam int BUSY_BIT  = 8;
	localparam int DONE_BIT  = 0;
	localparam int SEL_HI    = 15;
	localparam int SEL_LO    = 12;
	localparam int CLS_BIT   = 10;
	localparam int CLW_BIT   = 9;
	localparam int CLE_BIT   = 8;
	localparam int TRIG_HI   = 7;
	// =========================================================
	// address ranges of the indirect targets
	localparam logic [7:0] NVM_HI = 8'h1f;
	localparam logic [7:0] SHD_LO = 8'h40;
	localparam logic [7:0] SHD_HI = 8'h5f;
	// =========================================================
	// action selector codes and trigger bytes
	localparam logic [3:0] SEL_NONE      = 4'h0;
	localparam logic [3:0] SEL_MARGIN_LO = 4'h1;
	localparam logic [3:0] SEL_MARGIN_HI = 4'h2;
	localparam logic [3:0] SEL_TURNS     = 4'h4;
	localparam logic [3:0] SEL_RELOAD    = 4'h5;
	localparam logic [3:0] SEL_TRANSPORT = 4'h6;
	localparam logic [3:0] SEL_HARD_RST  = 4'h7;
	localparam logic [3:0] SEL_FE_TEST   = 4'h9;
	localparam logic [3:0] SEL_LOGIC_TST = 4'ha;
	localparam logic [3:0] SEL_BOTH_TST  = 4'hb;
	localparam logic [7:0] TRIG_UNLOCKED = 8'ha5;
	localparam logic [7:0] TRIG_TURNS    = 8'h46;
	localparam logic [7:0] TRIG_HARD_ALT = 8'h5a;
	localparam logic [7:0] TRIG_TEST     = 8'hb9;
	// =========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int NVM_WRITE_MS  = 24;
	localparam int NVM_READ_NS   = 2000;
	localparam int NVM_WRITE_CYC = NVM_WRITE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int NVM_READ_CYC  = NVM_READ_NS / CLK_PERIOD_NS;
	localparam int SHADOW_CYC    = 1;
	localparam int CNT_W_DEF     = 22;
	// action engine states
	typedef enum logic [0:0] {ACT_IDLE, ACT_RUN} act_state_t;
endpackage

// file: hw/access_timer.sv
/*
 * down-counter that times one indirect memory access.
 * assumes start is a one-cycle pulse and length is at least one.
 */
`timescale 1ns/1ps
module access_timer #(
	parameter int CNT_W = 22
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// control
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] length,
	// status
	output logic                  busy,
	output logic                  done
);
	logic [CNT_W-1:0] cnt_reg;
	logic             busy_reg;

	// =========================================================
	// busy for length cycles; done marks the last busy cycle so that
	// status flags and captured data change at the very edge where busy
	// falls, leaving no cycle in which neither busy nor done reads one
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
		end
		else
		begin
			if (start && !busy_reg)
			begin
				busy_reg <= 1'b1;
				cnt_reg  <= length;
			end
			else if (busy_reg)
			begin
				if (cnt_reg <= CNT_W'(1))
					busy_reg <= 1'b0;
				else
					cnt_reg <= cnt_reg - CNT_W'(1);
			end
		end
	end

	assign busy = busy_reg;
	assign done = busy_reg && (cnt_reg <= CNT_W'(1));
endmodule

// file: hw/nvm_access_ctrl.sv
/*
 * indirect nonvolatile/shadow access registers and device action control.
 * assumes the serial framing outside delivers single-cycle register strobes
 * on ref_clk, and that memory and action logic share the same clock.
 */
// Function
// - write target byte, nvm and shadow ranges
// - write value from two 16-bit halves
// - write start sets busy, clears done
// - write start bit reads zero
// - write busy bit 8 while writing
// - write done bit 0 until next start
// - read source byte, nvm and shadow ranges
// - nvm read takes about two microseconds
// - read start sets busy, clears done
// - read start bit reads zero
// - read busy bit 8, done bit 0
// - read result halves valid after done
// - selector bits 15:12, cleared on completion except for the margin selectors
// - margin selectors need unlock and 0xa5
// - turns counter reset with 0x46
// - reload needs unlock and 0xa5
// - transport mode armed until low power
// - hard reset of unlocked part
// - self-tests start with 0xb9, trigger reads zero
// - bit 10 clears action and boot done
// - bit 9 clears read warnings
// - bit 8 clears read errors
// - action done drops on trigger, rises after
`timescale 1ns/1ps
module nvm_access_ctrl #(
	parameter int WRITE_CYC = nvm_ctrl_pkg::NVM_WRITE_CYC,
	parameter int READ_CYC  = nvm_ctrl_pkg::NVM_READ_CYC,
	parameter int CNT_W     = nvm_ctrl_pkg::CNT_W_DEF
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	// memory port
	output logic             mem_wr_stb,
	output logic             mem_rd_stb,
	output logic      [7:0]  mem_addr,
	output logic      [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	// device actions
	input  wire logic        part_unlocked,
	input  wire logic        action_done_in,
	input  wire logic        boot_done_in,
	input  wire logic        low_power_mode,
	output logic             margin_low_en,
	output logic             margin_high_en,
	output logic             turns_reset_stb,
	output logic             reload_stb,
	output logic             hard_reset_stb,
	output logic             front_end_test_stb,
	output logic             logic_self_test_stb,
	output logic             transport_enter_stb,
	output logic             warn_clear_stb,
	output logic             err_clear_stb,
	output logic             special_done,
	output logic             boot_done
);
	import nvm_ctrl_pkg::*;

	logic [7:0]       write_target_reg;
	logic [15:0]      write_value_upper_field;
	logic [15:0]      write_value_lower_field;
	logic [7:0]       read_source_reg;
	logic [15:0]      read_result_upper_field;
	logic [15:0]      read_result_lower_field;
	logic             wr_done_reg;
	logic             rd_done_reg;
	logic             rd_valid_reg;
	logic             wr_busy;
	logic             wr_fin;
	logic             rd_busy;
	logic             rd_fin;
	logic             wr_start;
	logic             rd_start;
	logic [CNT_W-1:0] wr_len;
	logic [CNT_W-1:0] rd_len;
	logic             wr_valid;
	logic             rd_valid;
	logic             ctrl_wr;
	logic [3:0]       sel_wr;
	logic             trig_hit;
	logic             quick_act;
	logic [3:0]       sel_reg;
	logic             margin_on_reg;
	logic             transport_reg;
	logic             quick_reg;
	logic             sdn_reg;
	logic             bdn_reg;
	act_state_t       act_reg;
	logic [15:0]      rd_next;

	// =========================================================
	// target decode
	function automatic logic is_nvm(input logic [7:0] a);
		is_nvm = (a <= NVM_HI);
	endfunction
	function automatic logic is_shadow(input logic [7:0] a);
		is_shadow = (a >= SHD_LO) && (a <= SHD_HI);
	endfunction

	// =========================================================
	// write and read engines
	// start only when idle, a start while busy is dropped
	assign wr_start = reg_wr && (reg_addr == OFS_WR_STATE) && reg_wdata[START_BIT] && !wr_busy;
	assign rd_start = reg_wr && (reg_addr == OFS_RD_STATE) && reg_wdata[START_BIT] && !rd_busy;
	// only the two ranges reach the memory port
	assign wr_valid = is_nvm(write_target_reg) || is_shadow(write_target_reg);
	assign rd_valid = is_nvm(read_source_reg) || is_shadow(read_source_reg);
	// nvm programming time is covered by the busy window
	assign wr_len = is_nvm(write_target_reg) ? CNT_W'(WRITE_CYC) : CNT_W'(SHADOW_CYC);
	assign rd_len = is_nvm(read_source_reg) ? CNT_W'(READ_CYC) : CNT_W'(SHADOW_CYC);

	access_timer #(.CNT_W(CNT_W)) u_wr_timer (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.start   (wr_start),
		.length  (wr_len),
		.busy    (wr_busy),
		.done    (wr_fin)
	);

	access_timer #(.CNT_W(CNT_W)) u_rd_timer (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.start   (rd_start),
		.length  (rd_len),
		.busy    (rd_busy),
		.done    (rd_fin)
	);

	// host-writable address and data registers
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			write_target_reg        <= 8'h00;
			write_value_upper_field <= 16'h0000;
			write_value_lower_field <= 16'h0000;
			read_source_reg         <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == OFS_WR_TARGET)
				write_target_reg <= reg_wdata[7:0];
			if (reg_addr == OFS_WR_UPPER)
				write_value_upper_field <= reg_wdata;
			if (reg_addr == OFS_WR_LOWER)
				write_value_lower_field <= reg_wdata;
			if (reg_addr == OFS_RD_SOURCE)
				read_source_reg <= reg_wdata[7:0];
		end
	end

	// memory strobes; an out-of-range target completes without a strobe
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			mem_wr_stb <= 1'b0;
			mem_rd_stb <= 1'b0;
			mem_addr   <= 8'h00;
			mem_wdata  <= 32'h0000_0000;
		end
		else
		begin
			mem_wr_stb <= wr_start && wr_valid;
			mem_rd_stb <= rd_start && rd_valid;
			if (wr_start)
			begin
				mem_addr <= write_target_reg;
				mem_wdata <= {write_value_upper_field, write_value_lower_field};
			end
			else if (rd_start)
				mem_addr <= read_source_reg;
		end
	end

	// done flags: cleared by start, set by the timer end
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wr_done_reg  <= 1'b0;
			rd_done_reg  <= 1'b0;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			if (wr_start)
				wr_done_reg <= 1'b0;
			else if (wr_fin)
				wr_done_reg <= 1'b1;
			if (rd_start)
			begin
				rd_done_reg  <= 1'b0;
				rd_valid_reg <= rd_valid;
			end
			else if (rd_fin)
				rd_done_reg <= 1'b1;
		end
	end

	// result captured at completion, zero for an unmapped source
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			read_result_upper_field <= 16'h0000;
			read_result_lower_field <= 16'h0000;
		end
		else if (rd_fin)
		begin
			read_result_upper_field <= rd_valid_reg ? mem_rdata[31:16] : 16'h0000;
			read_result_lower_field <= rd_valid_reg ? mem_rdata[15:0] : 16'h0000;
		end
	end

	// =========================================================
	// device action engine
	assign ctrl_wr = reg_wr && (reg_addr == OFS_CTRL);
	assign sel_wr  = reg_wdata[SEL_HI:SEL_LO];

	// the trigger must match the selector, else nothing starts
	always_comb
	begin
		trig_hit  = 1'b0;
		quick_act = 1'b0;
		case (sel_wr)
			SEL_MARGIN_LO, SEL_MARGIN_HI:
			begin
				trig_hit  = part_unlocked && (reg_wdata[TRIG_HI:0] == TRIG_UNLOCKED);
				quick_act = 1'b1;
			end
			SEL_TURNS:
			begin
				trig_hit  = (reg_wdata[TRIG_HI:0] == TRIG_TURNS);
				quick_act = 1'b1;
			end
			SEL_RELOAD:
				trig_hit = part_unlocked && (reg_wdata[TRIG_HI:0] == TRIG_UNLOCKED);
			SEL_HARD_RST:
				trig_hit = part_unlocked && ((reg_wdata[TRIG_HI:0] == TRIG_UNLOCKED) ||
					(reg_wdata[TRIG_HI:0] == TRIG_HARD_ALT));
			SEL_FE_TEST, SEL_LOGIC_TST, SEL_BOTH_TST:
				trig_hit = (reg_wdata[TRIG_HI:0] == TRIG_TEST);
			default:
				trig_hit = 1'b0;
		endcase
	end

	// selector, state and action strobes; selector is frozen while running
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			act_reg             <= ACT_IDLE;
			sel_reg             <= SEL_NONE;
			quick_reg           <= 1'b0;
			margin_on_reg       <= 1'b0;
			transport_reg       <= 1'b0;
			turns_reset_stb     <= 1'b0;
			reload_stb          <= 1'b0;
			hard_reset_stb      <= 1'b0;
			front_end_test_stb  <= 1'b0;
			logic_self_test_stb <= 1'b0;
			transport_enter_stb <= 1'b0;
		end
		else
		begin
			turns_reset_stb     <= 1'b0;
			reload_stb          <= 1'b0;
			hard_reset_stb      <= 1'b0;
			front_end_test_stb  <= 1'b0;
			logic_self_test_stb <= 1'b0;
			transport_enter_stb <= 1'b0;
			case (act_reg)
				ACT_IDLE:
				begin
					if (ctrl_wr)
					begin
						sel_reg       <= sel_wr;
						margin_on_reg <= 1'b0;
						transport_reg <= (sel_wr == SEL_TRANSPORT);
						if (trig_hit)
						begin
							act_reg             <= ACT_RUN;
							quick_reg           <= quick_act;
							margin_on_reg       <= (sel_wr == SEL_MARGIN_LO) || (sel_wr == SEL_MARGIN_HI);
							turns_reset_stb     <= (sel_wr == SEL_TURNS);
							reload_stb          <= (sel_wr == SEL_RELOAD);
							hard_reset_stb      <= (sel_wr == SEL_HARD_RST);
							front_end_test_stb  <= (sel_wr == SEL_FE_TEST) || (sel_wr == SEL_BOTH_TST);
							logic_self_test_stb <= (sel_wr == SEL_LOGIC_TST) || (sel_wr == SEL_BOTH_TST);
						end
					end
					else if (transport_reg && low_power_mode)
					begin
						// takes effect on low power entry, then completes
						transport_enter_stb <= 1'b1;
						transport_reg       <= 1'b0;
						sel_reg             <= SEL_NONE;
					end
				end
				ACT_RUN:
				begin
					if (quick_reg || action_done_in)
					begin
						act_reg <= ACT_IDLE;
						if (!margin_on_reg)
							sel_reg <= SEL_NONE;
					end
				end
				default:
					act_reg <= ACT_IDLE;
			endcase
		end
	end

	assign margin_low_en  = margin_on_reg && (sel_reg == SEL_MARGIN_LO);
	assign margin_high_en = margin_on_reg && (sel_reg == SEL_MARGIN_HI);

	// status flags: hardware set wins over a software clear
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sdn_reg <= 1'b0;
			bdn_reg <= 1'b0;
		end
		else
		begin
			// drop on trigger, rise on finish
			if (act_reg == ACT_RUN && (quick_reg || action_done_in))
				sdn_reg <= 1'b1;
			else if (act_reg == ACT_IDLE && ctrl_wr && trig_hit)
				sdn_reg <= 1'b0;
			else if (ctrl_wr && reg_wdata[CLS_BIT])
				sdn_reg <= 1'b0;
			if (boot_done_in)
				bdn_reg <= 1'b1;
			else if (ctrl_wr && reg_wdata[CLS_BIT])
				bdn_reg <= 1'b0;
		end
	end

	// clear pulses toward the warning and error latches
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			warn_clear_stb <= 1'b0;
			err_clear_stb  <= 1'b0;
		end
		else
		begin
			warn_clear_stb <= ctrl_wr && reg_wdata[CLW_BIT];
			err_clear_stb  <= ctrl_wr && reg_wdata[CLE_BIT];
		end
	end

	assign special_done = sdn_reg;
	assign boot_done    = bdn_reg;

	// =========================================================
	// register readback; start, clear and trigger bits always read zero
	always_comb
	begin
		rd_next = 16'h0000;
		case (reg_addr)
			OFS_WR_TARGET: rd_next = {8'h00, write_target_reg};
			OFS_WR_UPPER:  rd_next = write_value_upper_field;
			OFS_WR_LOWER:  rd_next = write_value_lower_field;
			OFS_WR_STATE:  rd_next = {7'h00, wr_busy, 7'h00, wr_done_reg};
			OFS_RD_SOURCE: rd_next = {8'h00, read_source_reg};
			OFS_RD_STATE:  rd_next = {7'h00, rd_busy, 7'h00, rd_done_reg};
			OFS_RD_UPPER:  rd_next = read_result_upper_field;
			OFS_RD_LOWER:  rd_next = read_result_lower_field;
			OFS_CTRL:      rd_next = {sel_reg, 12'h000};
			default:       rd_next = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_next;
		end
	end

	// =========================================================
	// checks
	chk_wr_start_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_start |=> wr_busy && !wr_done_reg)
		else $error("write start did not set busy and clear done");
	chk_wr_done_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_done_reg && !wr_start |=> wr_done_reg)
		else $error("write done dropped without a new start");
	chk_wr_state_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_rd && reg_addr == OFS_WR_STATE |=> reg_rdata[START_BIT] == 1'b0 && reg_rdata[BUSY_BIT] == $past(wr_busy))
		else $error("write state readback wrong");
	chk_rd_shadow_time: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_start && is_shadow(read_source_reg) |=> rd_busy ##1 rd_done_reg)
		else $error("shadow read did not finish in two cycles");
	chk_rd_nvm_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_start && is_nvm(read_source_reg) |=> rd_busy [*8])
		else $error("nvm read finished too early");
	chk_sdn_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
		act_reg == ACT_IDLE && ctrl_wr && trig_hit |=> !sdn_reg)
		else $error("action done flag not cleared on trigger");
	chk_bad_trig: assert property (@(posedge ref_clk) disable iff (sys_rst)
		act_reg == ACT_IDLE && ctrl_wr && !trig_hit && !reg_wdata[CLS_BIT] |=> act_reg == ACT_IDLE && $stable(sdn_reg))
		else $error("mismatched trigger changed state");
	chk_cls_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ctrl_wr && reg_wdata[CLS_BIT] && !boot_done_in |=> !bdn_reg)
		else $error("boot done not cleared");
	chk_clear_pulses: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ctrl_wr && reg_wdata[CLE_BIT] |=> err_clear_stb ##1 !err_clear_stb || ($past(ctrl_wr) && $past(reg_wdata[CLE_BIT])))
		else $error("error clear pulse wrong");
	chk_sel_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
		act_reg == ACT_RUN && action_done_in && !quick_reg |=> sel_reg == SEL_NONE && sdn_reg)
		else $error("selector not cleared on completion");
endmodule

// file: test/mem_model.sv
/*
 * memory model on the far side of the indirect access port, 256 words of 32 bits.
 * assumes the design strobes only valid places and holds mem_addr from the strobe on.
 */
`timescale 1ns/1ps
module mem_model (
	// clock
	input  wire logic        ref_clk,
	// memory port
	input  wire logic        mem_wr_stb,
	input  wire logic [7:0]  mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic      [31:0] mem_rdata
);
	logic [31:0] mem_reg [256];
	// =========================================================
	// storage
	// nvm and shadow words
	initial
	begin
		foreach (mem_reg[i])
			mem_reg[i] = 32'h0000_0000;
	end
	always @(posedge ref_clk)
	begin
		if (mem_wr_stb)
			mem_reg[mem_addr] <= mem_wdata;
	end
	// read is asynchronous, so the word stays steady while mem_addr is held
	assign mem_rdata = mem_reg[mem_addr];
endmodule

// file: test/nvm_access_ctrl_test.sv
/*
 * self-checking bench for the indirect access and device action registers.
 * assumes short access timers via parameters; strobes are counted by a monitor.
 */
`timescale 1ns/1ps
module nvm_access_ctrl_test;
	import nvm_ctrl_pkg::*;
	logic        ref_clk, sys_rst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid;
	logic [7:0]  reg_addr = 0, mem_addr;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic [31:0] mem_wdata, mem_rdata;
	logic        part_unlocked = 0, action_done_in = 0, boot_done_in = 0, low_power_mode = 0;
	logic        mem_wr_stb, mem_rd_stb, margin_low_en, margin_high_en, special_done, boot_done;
	logic        turns_reset_stb, reload_stb, hard_reset_stb, front_end_test_stb, logic_self_test_stb;
	logic        transport_enter_stb, warn_clear_stb, err_clear_stb;
	int          n_mismatch = 0, checks = 0;
	int          cnt [10] = '{default: 0};
	int          exp_cnt [10] = '{default: 0};
	int unsigned exp_mem [256] = '{default: 0};
	logic [9:0]  stb;
	// =========================================================
	// clock, design and partner
	initial
	begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	nvm_access_ctrl #(.WRITE_CYC(20), .READ_CYC(10), .CNT_W(22)) u_nvm_access_ctrl (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mem_wr_stb(mem_wr_stb), .mem_rd_stb(mem_rd_stb),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .part_unlocked(part_unlocked),
		.action_done_in(action_done_in), .boot_done_in(boot_done_in), .low_power_mode(low_power_mode),
		.margin_low_en(margin_low_en), .margin_high_en(margin_high_en), .turns_reset_stb(turns_reset_stb),
		.reload_stb(reload_stb), .hard_reset_stb(hard_reset_stb), .front_end_test_stb(front_end_test_stb),
		.logic_self_test_stb(logic_self_test_stb), .transport_enter_stb(transport_enter_stb),
		.warn_clear_stb(warn_clear_stb), .err_clear_stb(err_clear_stb), .special_done(special_done),
		.boot_done(boot_done));
	mem_model u_mem_model (.ref_clk(ref_clk), .mem_wr_stb(mem_wr_stb), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	// pulse counting avoids guessing the exact strobe cycle
	assign stb = {mem_rd_stb, mem_wr_stb, err_clear_stb, warn_clear_stb, transport_enter_stb,
		logic_self_test_stb, front_end_test_stb, hard_reset_stb, reload_stb, turns_reset_stb};
	always @(posedge ref_clk)
	begin
		for (int j = 0; j < 10; j++)
			cnt[j] += (stb[j] === 1'b1);
	end
	// =========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic results();
		$display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// fixed one-cycle answer, sampled once the edge has settled
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rvalid, 1, "read answer");
		d = reg_rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string msg);
		logic [15:0] v;
		rd(a, v);
		chk(v, exp, msg);
	endtask
	task automatic poll(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		v = 16'h0000;
		for (int n = 0; n < 100 && v !== exp; n++)
			rd(a, v);
		chk(v, exp, "wait ran out");
		if (v !== exp)
			results();
	endtask
	task automatic kick(input int k);
		@(posedge ref_clk);
		action_done_in <= (k == 1);
		low_power_mode <= (k == 2);
		boot_done_in <= (k == 3);
		@(posedge ref_clk);
		{action_done_in, low_power_mode, boot_done_in} <= 3'b000;
		#1;
	endtask
	task automatic cnt_chk();
		for (int j = 0; j < 10; j++)
			chk(cnt[j], exp_cnt[j], "strobe count");
	endtask
	// =========================================================
	// main sequence
	initial
	begin
		logic [7:0]  a;
		logic [15:0] hi, lo;
		static logic [15:0] aw [12] = '{16'h4046, 16'h50a5, 16'h705a, 16'h70a5, 16'h90b9, 16'ha0b9, 16'hb0b9,
			16'h10a5, 16'h20a5, 16'h6000, 16'h40a5, 16'h50a5};
		static logic        au [12] = '{1, 1, 1, 1, 0, 0, 0, 1, 1, 0, 1, 0};
		static logic [11:0] am [12] = '{12'h001, 12'h002, 12'h004, 12'h004, 12'h008, 12'h010, 12'h018, 12'h400,
			12'h800, 12'h020, 12'h000, 12'h000};
		static int          ak [12] = '{0, 1, 1, 1, 1, 1, 1, 0, 0, 2, 0, 0};
		static logic [7:0]  ofs [10] = '{OFS_WR_TARGET, OFS_WR_UPPER, OFS_WR_LOWER, OFS_WR_STATE, OFS_RD_SOURCE,
			OFS_RD_STATE, OFS_RD_UPPER, OFS_RD_LOWER, OFS_CTRL, 8'h12};
		logic        ok, go, sd;
		void'($urandom(32'h8d8f55a1));
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		// reset values, with a write to an unmapped place first
		wr(8'h12, 16'hffff);
		for (int i = 0; i < 10; i++)
			rchk(ofs[i], 16'h0000, "reset value");
		$display("test reset done");
		// indirect write and read: nvm, shadow, then an invalid place
		for (int i = 0; i < 3; i++)
		begin
			a = (i == 0) ? 8'($urandom_range(31)) : (i == 1) ? 8'(8'h40 + $urandom_range(31)) : 8'h80;
			hi = 16'($urandom);
			lo = 16'($urandom);
			ok = (a <= NVM_HI) || (a >= SHD_LO && a <= SHD_HI);
			wr(OFS_WR_TARGET, {8'hff, a});
			wr(OFS_WR_UPPER, hi);
			wr(OFS_WR_LOWER, lo);
			rchk(OFS_WR_TARGET, {8'h00, a}, "write target");
			rchk(OFS_WR_UPPER, hi, "write upper");
			rchk(OFS_WR_LOWER, lo, "write lower");
			wr(OFS_WR_STATE, 16'h8000);
			rchk(OFS_WR_STATE, (a <= NVM_HI) ? 16'h0100 : 16'h0001, "write state");
			poll(OFS_WR_STATE, 16'h0001);
			if (ok)
				exp_mem[a] = {hi, lo};
			exp_cnt[8] += ok;
			wr(OFS_RD_SOURCE, {8'hff, a});
			rchk(OFS_RD_SOURCE, {8'h00, a}, "read source");
			wr(OFS_RD_STATE, 16'h8000);
			rchk(OFS_RD_STATE, (a <= NVM_HI) ? 16'h0100 : 16'h0001, "read state");
			poll(OFS_RD_STATE, 16'h0001);
			exp_cnt[9] += ok;
			rchk(OFS_RD_UPPER, 16'(exp_mem[a] >> 16), "read upper");
			rchk(OFS_RD_LOWER, 16'(exp_mem[a]), "read lower");
		end
		cnt_chk();
		$display("test indirect done");
		// every action code, then a wrong trigger and a locked part
		for (int i = 0; i < 12; i++)
		begin
			@(posedge ref_clk);
			part_unlocked <= au[i];
			go = (am[i] != 12'h000);
			sd = special_done;
			wr(OFS_CTRL, aw[i]);
			#1;
			if (ak[i] == 1)
				chk(special_done, 0, "action running");
			if (ak[i] != 0)
				kick(ak[i]);
			repeat (2) @(posedge ref_clk);
			#1;
			if (ak[i] != 2)
				chk(special_done, go ? 1'b1 : sd, "action done");
			for (int j = 0; j < 10; j++)
				exp_cnt[j] += am[i][j];
			cnt_chk();
			chk(margin_low_en, am[i][10], "low margin");
			chk(margin_high_en, am[i][11], "high margin");
			rchk(OFS_CTRL, (go && am[i][11:10] == 2'b00) ? 16'h0000 : {aw[i][15:12], 12'h000}, "ctrl");
		end
		$display("test actions done");
		// clear bits
		kick(3);
		chk(boot_done, 1, "boot done");
		wr(OFS_CTRL, 16'h0700);
		@(posedge ref_clk);
		#1;
		chk(special_done, 0, "status clear");
		chk(boot_done, 0, "boot clear");
		exp_cnt[6]++;
		exp_cnt[7]++;
		cnt_chk();
		rchk(OFS_CTRL, 16'h0000, "clear bits read");
		$display("test clears done");
		results();
	end
endmodule
